// ### design/port_alt_function_override_pkg.sv
// constants for the port alternate-function override block
// assumes one 20 MHz clock and a synchronous active-high reset

package port_alt_function_override_pkg;
	localparam int PORT_A_WIDTH = 8;
	localparam int PIN_COUNT = 9;
	localparam int PIN_REF = 0;
	localparam int PIN_SER_CLK = 4;
	localparam int PIN_DATA_OUT = 5;
	localparam int PIN_DATA_IN = 6;
	localparam int PIN_CAPTURE = 7;
	localparam int PIN_OSC = 8;
	localparam logic [8:0] PAD_OUT_RST = 9'h000;
	localparam logic [8:0] PAD_OE_N_RST = 9'h1ff;
	localparam logic [8:0] PAD_PULLUP_RST = 9'h000;
	localparam logic [8:0] INPUT_EN_RST = 9'h000;
	localparam logic [8:0] SYNC_RST = 9'h000;
endpackage : port_alt_function_override_pkg

// ### design/port_alt_function_override.sv
// pad override logic for the eight-pin first port and pin 0 of the second port
// assumes the port registers and peripherals sit on clk_in; pad inputs are asynchronous
`timescale 1ns/1ps

module port_alt_function_override (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic [7:0] port_a_out_in,
	input wire logic [7:0] port_a_dir_in,
	input wire logic port_b_out0_in,
	input wire logic port_b_dir0_in,
	input wire logic pullup_disable_in,
	input wire logic sleep_in,
	input wire logic [7:0] analog_input_disable_in,
	input wire logic [8:0] pin_change_src_in,
	input wire logic pin_change_group0_en_in,
	input wire logic pin_change_group1_en_in,
	input wire logic serial_wire_mode_b1_in,
	input wire logic serial_wire_mode_b0_in,
	input wire logic serial_start_irq_en_in,
	input wire logic serial_clk_hold_in,
	input wire logic serial_clk_toggle_in,
	input wire logic serial_data_out_in,
	input wire logic serial_sda_out_in,
	input wire logic timer1_cmp_a_en_in,
	input wire logic timer1_cmp_a_out_in,
	input wire logic timer1_cmp_b_en_in,
	input wire logic timer1_cmp_b_out_in,
	input wire logic timer0_cmp_b_en_in,
	input wire logic timer0_cmp_b_out_in,
	input wire logic ref_select_b1_in,
	input wire logic ref_select_b0_in,
	input wire logic osc_is_rc_in,
	input wire logic [8:0] pad_in,
	output logic [8:0] pad_out,
	output logic [8:0] pad_oe_n_out,
	output logic [8:0] pad_pullup_out,
	output logic [8:0] digital_in_out,
	output logic [8:0] pin_change_out,
	output logic serial_clk_in_out,
	output logic serial_data_in_out,
	output logic timer1_capture_in_out
);

	// register bits of all nine pins gathered into vectors
	wire [8:0] port_out = {port_b_out0_in, port_a_out_in};
	wire [8:0] port_dir = {port_b_dir0_in, port_a_dir_in};
	wire [7:0] pc_g0 = pin_change_src_in[7:0] & {8{pin_change_group0_en_in}};
	wire pc8_g1 = pin_change_src_in[8] & pin_change_group1_en_in;
	wire wm1 = serial_wire_mode_b1_in;
	wire wm0 = serial_wire_mode_b0_in;
	wire sie = serial_start_irq_en_in;
	wire [7:0] adc_dis = analog_input_disable_in;
	wire osc_pin = ~osc_is_rc_in;

	// pin 0: released for an external reference outside reset
	wire ref_release = ~srst_in & ((~ref_select_b1_in & ref_select_b0_in)
		| (ref_select_b1_in & ref_select_b0_in));

	// pin 4: two-wire serial clock
	wire p4_dir_oe = wm1;
	wire p4_dir_ov = ~(serial_clk_hold_in | port_out[4]) & port_dir[4];
	wire p4_val_oe = wm1 & port_dir[4];

	// pin 5: serial data-out or compare B
	wire p5_val_oe = (wm1 & wm0) | timer1_cmp_b_en_in;
	wire p5_val_ov = (wm1 & wm0) ? serial_data_out_in : timer1_cmp_b_out_in;

	// pin 6: two-wire data or compare A
	wire p6_dir_oe = wm1;
	wire p6_dir_ov = (serial_sda_out_in | port_out[6]) & port_dir[6];
	wire p6_val_oe = (wm1 & port_dir[6]) | timer1_cmp_a_en_in;
	wire p6_val_ov = ~(wm1 & port_dir[6]) & timer1_cmp_a_out_in;

	// pin 7: timer 0 compare B
	wire p7_val_oe = timer0_cmp_b_en_in;
	wire p7_val_ov = timer0_cmp_b_out_in;

	// override enables and values per pin, pin 8 is the oscillator pin
	wire [8:0] pu_oe = {osc_pin, 7'h00, ref_release};
	wire [8:0] pu_ov = 9'h000;
	wire [8:0] dir_oe = {osc_pin, 1'b0, p6_dir_oe, 1'b0, p4_dir_oe, 3'h0, ref_release};
	wire [8:0] dir_ov = {1'b0, 1'b0, p6_dir_ov, 1'b0, p4_dir_ov, 4'h0};
	wire [8:0] val_oe = {osc_pin, p7_val_oe, p6_val_oe, p5_val_oe, p4_val_oe,
		3'h0, ref_release};
	wire [8:0] val_ov = {1'b0, p7_val_ov, p6_val_ov, p5_val_ov, 5'h00};
	wire [8:0] tog_oe = {4'h0, serial_clk_toggle_in, 4'h0};

	// digital-input override per pin
	wire [8:0] ien_oe;
	wire [8:0] ien_ov;
	assign ien_oe[0] = pc_g0[0] | adc_dis[0];
	assign ien_oe[1] = pc_g0[1] | adc_dis[1];
	assign ien_oe[2] = pc_g0[2] | adc_dis[2];
	assign ien_oe[3] = pc_g0[3] | adc_dis[3];
	assign ien_oe[4] = sie | pc_g0[4] | adc_dis[4];
	assign ien_oe[5] = pc_g0[5] | adc_dis[5];
	assign ien_oe[6] = sie | pc_g0[6] | adc_dis[6];
	assign ien_oe[7] = pc_g0[7] | adc_dis[7];
	assign ien_oe[8] = osc_pin | pc8_g1;
	assign ien_ov[3:0] = pc_g0[3:0];
	assign ien_ov[4] = sie | pc_g0[4];
	assign ien_ov[5] = pc_g0[5];
	assign ien_ov[6] = sie | pc_g0[6];
	assign ien_ov[7] = pc_g0[7];
	assign ien_ov[8] = ~osc_pin & pc8_g1;

	// next pad state per pin
	logic [8:0] next_out;
	logic [8:0] next_drive;
	logic [8:0] next_pullup;
	logic [8:0] next_ien;
	genvar i;
	generate
		for (i = 0; i < port_alt_function_override_pkg::PIN_COUNT; i++) begin : g_pin
			wire reg_bit = port_out[i] ^ tog_oe[i];
			wire plain_pu = ~port_dir[i] & port_out[i] & ~pullup_disable_in;
			assign next_drive[i] = dir_oe[i] ? dir_ov[i] : port_dir[i];
			assign next_out[i] = val_oe[i] ? val_ov[i] : reg_bit;
			assign next_pullup[i] = pu_oe[i] ? pu_ov[i] : plain_pu;
			assign next_ien[i] = ien_oe[i] ? ien_ov[i] : ~sleep_in;
		end
	endgenerate

	// pad-facing registers
	logic [8:0] input_en;
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			pad_out <= port_alt_function_override_pkg::PAD_OUT_RST;
			pad_oe_n_out <= port_alt_function_override_pkg::PAD_OE_N_RST;
			pad_pullup_out <= port_alt_function_override_pkg::PAD_PULLUP_RST;
			input_en <= port_alt_function_override_pkg::INPUT_EN_RST;
		end else begin
			pad_out <= next_out;
			pad_oe_n_out <= ~next_drive; // low while driving
			pad_pullup_out <= next_pullup;
			input_en <= next_ien;
		end
	end

	// two-flop synchroniser for pad levels
	logic [8:0] sync_a;
	logic [8:0] sync_b;
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			sync_a <= port_alt_function_override_pkg::SYNC_RST;
			sync_b <= port_alt_function_override_pkg::SYNC_RST;
		end else begin
			sync_a <= pad_in;
			sync_b <= sync_a;
		end
	end

	// gated digital inputs and their consumers
	wire [8:0] next_din = sync_b & input_en;
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			digital_in_out <= port_alt_function_override_pkg::SYNC_RST;
			pin_change_out <= port_alt_function_override_pkg::SYNC_RST;
			serial_clk_in_out <= 1'b0;
			serial_data_in_out <= 1'b0;
			timer1_capture_in_out <= 1'b0;
		end else begin
			digital_in_out <= next_din;
			pin_change_out <= next_din;
			serial_clk_in_out <= next_din[port_alt_function_override_pkg::PIN_SER_CLK];
			serial_data_in_out <= next_din[port_alt_function_override_pkg::PIN_DATA_IN];
			timer1_capture_in_out <= next_din[port_alt_function_override_pkg::PIN_CAPTURE];
		end
	end

	// checks: three-wire data-out on pin 5
	sequence three_wire_drive_s;
		wm1 && wm0 && port_dir[5];
	endsequence

	pin5_serial_out_a: assert property (@(posedge clk_in) disable iff (srst_in)
		three_wire_drive_s |=> (!pad_oe_n_out[5] && pad_out[5] == $past(serial_data_out_in)))
		else $error("pin 5 does not carry serial data-out");

	pin5_serial_idle_a: assert property (@(posedge clk_in) disable iff (srst_in)
		(wm1 && wm0 && !port_dir[5]) |=> pad_oe_n_out[5])
		else $error("pin 5 driven while an input");

	// pull-up on pin 5 still follows its output bit while serial mode owns the value
	pin5_pullup_a: assert property (@(posedge clk_in) disable iff (srst_in)
		(wm1 && wm0 && !port_dir[5] && port_out[5] && !pullup_disable_in) |=> pad_pullup_out[5])
		else $error("pin 5 pull-up lost in serial mode");

	// compare B only reaches the pad through the direction bit
	pin5_compare_b_a: assert property (@(posedge clk_in) disable iff (srst_in)
		(timer1_cmp_b_en_in && !(wm1 && wm0)) |=>
		(pad_out[5] == $past(timer1_cmp_b_out_in) && pad_oe_n_out[5] == !$past(port_dir[5])))
		else $error("pin 5 compare B routing wrong");

	// with neither serial mode nor compare B, pin 5 shows its output bit
	pin5_plain_value_a: assert property (@(posedge clk_in) disable iff (srst_in)
		(!(wm1 && wm0) && !timer1_cmp_b_en_in) |=> pad_out[5] == $past(port_out[5]))
		else $error("pin 5 value override without cause");

	// two-wire data driver on pin 6
	pin6_driver_a: assert property (@(posedge clk_in) disable iff (srst_in)
		wm1 |=> (pad_oe_n_out[6] == !$past((serial_sda_out_in | port_out[6]) & port_dir[6])))
		else $error("pin 6 two-wire driver wrong");

	pin6_compare_a_a: assert property (@(posedge clk_in) disable iff (srst_in)
		(timer1_cmp_a_en_in && !wm1) |=> pad_out[6] == $past(timer1_cmp_a_out_in))
		else $error("pin 6 compare A routing wrong");

	pin6_dir_plain_a: assert property (@(posedge clk_in) disable iff (srst_in)
		(timer1_cmp_a_en_in && !wm1) |=> pad_oe_n_out[6] == !$past(port_dir[6]))
		else $error("pin 6 compare A driver wrong");

	// a driving two-wire data pin without compare A is pulled to zero
	sequence two_wire_data_s;
		wm1 && port_dir[6] && !timer1_cmp_a_en_in;
	endsequence

	pin6_two_wire_low_a: assert property (@(posedge clk_in) disable iff (srst_in)
		two_wire_data_s |=> !pad_out[6])
		else $error("pin 6 two-wire value wrong");

	pin6_start_input_a: assert property (@(posedge clk_in) disable iff (srst_in)
		(serial_start_irq_en_in || (pin_change_src_in[6] && pin_change_group0_en_in))
		|=> input_en[6])
		else $error("pin 6 input not forced on");

	// two-wire clock on pin 4: driver from hold and output bit, value held at zero
	sequence two_wire_clk_s;
		wm1 && port_dir[4];
	endsequence

	pin4_clock_dir_a: assert property (@(posedge clk_in) disable iff (srst_in)
		wm1 |=> pad_oe_n_out[4] == !$past(~(serial_clk_hold_in | port_out[4]) & port_dir[4]))
		else $error("pin 4 clock driver wrong");

	pin4_clock_low_a: assert property (@(posedge clk_in) disable iff (srst_in)
		two_wire_clk_s |=> !pad_out[4])
		else $error("pin 4 clock value wrong");

	pin4_toggle_a: assert property (@(posedge clk_in) disable iff (srst_in)
		(!wm1 && serial_clk_toggle_in) |=> pad_out[4] == !$past(port_out[4]))
		else $error("pin 4 toggle not applied");

	pin4_start_input_a: assert property (@(posedge clk_in) disable iff (srst_in)
		(serial_start_irq_en_in || (pin_change_src_in[4] && pin_change_group0_en_in))
		|=> input_en[4])
		else $error("pin 4 input not forced on");

	// pin 0 released for the analog reference
	pin0_reference_a: assert property (@(posedge clk_in) disable iff (srst_in)
		ref_select_b0_in |=> (pad_oe_n_out[0] && !pad_pullup_out[0] && !pad_out[0]))
		else $error("pin 0 not released for reference");

	// second-port pin 0 as oscillator pin: no driver, no pull-up, no digital input
	osc_pin_idle_a: assert property (@(posedge clk_in) disable iff (srst_in)
		!osc_is_rc_in |=> (pad_oe_n_out[8] && !pad_pullup_out[8] && !input_en[8]))
		else $error("oscillator pin still acts as io");

	osc_pin_change_a: assert property (@(posedge clk_in) disable iff (srst_in)
		(osc_is_rc_in && pin_change_src_in[8] && pin_change_group1_en_in) |=> input_en[8])
		else $error("second-port pin 0 change input off");

	// pin 7 compare output from timer 0, driver still from the direction bit
	pin7_compare_a: assert property (@(posedge clk_in) disable iff (srst_in)
		timer0_cmp_b_en_in |=> pad_out[7] == $past(timer0_cmp_b_out_in))
		else $error("pin 7 compare value wrong");

	pin7_driver_a: assert property (@(posedge clk_in) disable iff (srst_in)
		timer0_cmp_b_en_in |=> pad_oe_n_out[7] == !$past(port_dir[7]))
		else $error("pin 7 compare driver wrong");

	// a steady high level on pin 7 reaches the capture input three edges later
	sequence pin7_high_s;
		(input_en[7] && pad_in[7]) [*3];
	endsequence

	capture_path_a: assert property (@(posedge clk_in) disable iff (srst_in)
		pin7_high_s ##0 (!sleep_in && !ien_oe[7]) [*2] |=> timer1_capture_in_out)
		else $error("pin 7 level does not reach capture");

	// pin change term forces the input on for pins 0 to 7
	pin7_change_input_a: assert property (@(posedge clk_in) disable iff (srst_in)
		(pin_change_src_in[7] && pin_change_group0_en_in) |=> input_en[7])
		else $error("pin 7 change input off");

	pin5_change_input_a: assert property (@(posedge clk_in) disable iff (srst_in)
		(pin_change_src_in[5] && pin_change_group0_en_in) |=> input_en[5])
		else $error("pin 5 change input off");

	pin3_change_input_a: assert property (@(posedge clk_in) disable iff (srst_in)
		(pin_change_src_in[3] && pin_change_group0_en_in) |=> input_en[3])
		else $error("pin 3 change input off");

	pin2_change_input_a: assert property (@(posedge clk_in) disable iff (srst_in)
		(pin_change_src_in[2] && pin_change_group0_en_in) |=> input_en[2])
		else $error("pin 2 change input off");

	pin1_change_input_a: assert property (@(posedge clk_in) disable iff (srst_in)
		(pin_change_src_in[1] && pin_change_group0_en_in) |=> input_en[1])
		else $error("pin 1 change input off");

	pin0_change_input_a: assert property (@(posedge clk_in) disable iff (srst_in)
		(pin_change_src_in[0] && pin_change_group0_en_in) |=> input_en[0])
		else $error("pin 0 change input off");

	// analog disable without a pin change or serial start term turns the input off
	input_override_a: assert property (@(posedge clk_in) disable iff (srst_in)
		(adc_dis[3] && !pc_g0[3]) |=> !input_en[3])
		else $error("pin 3 analog disable ignored");

	pin0_analog_off_a: assert property (@(posedge clk_in) disable iff (srst_in)
		(adc_dis[0] && !pc_g0[0]) |=> !input_en[0])
		else $error("pin 0 analog disable ignored");

	// generic override mechanics, one set per pin
	generate
		for (i = 0; i < port_alt_function_override_pkg::PIN_COUNT; i++) begin : g_chk
			dir_override_a: assert property (@(posedge clk_in) disable iff (srst_in)
				dir_oe[i] |=> pad_oe_n_out[i] == !$past(dir_ov[i]))
				else $error("direction override not applied");
			dir_plain_a: assert property (@(posedge clk_in) disable iff (srst_in)
				!dir_oe[i] |=> pad_oe_n_out[i] == !$past(port_dir[i]))
				else $error("direction bit not applied");
			value_override_a: assert property (@(posedge clk_in) disable iff (srst_in)
				val_oe[i] |=> pad_out[i] == $past(val_ov[i]))
				else $error("value override not applied");
			value_plain_a: assert property (@(posedge clk_in) disable iff (srst_in)
				!val_oe[i] |=> pad_out[i] == $past(port_out[i] ^ tog_oe[i]))
				else $error("output bit or toggle not applied");
			input_override_en_a: assert property (@(posedge clk_in) disable iff (srst_in)
				ien_oe[i] |=> input_en[i] == $past(ien_ov[i]))
				else $error("input enable override not applied");
			input_plain_a: assert property (@(posedge clk_in) disable iff (srst_in)
				!ien_oe[i] |=> input_en[i] == !$past(sleep_in))
				else $error("input enable does not follow sleep");
			change_feed_a: assert property (@(posedge clk_in) disable iff (srst_in)
				(sync_b[i] && input_en[i]) |=> pin_change_out[i])
				else $error("pin change source not fed");
		end
	endgenerate

	// reset parks every pad: no driver, no pull-up, value low
	reset_state_a: assert property (@(posedge clk_in)
		srst_in |=> (pad_oe_n_out == port_alt_function_override_pkg::PAD_OE_N_RST
		&& pad_pullup_out == port_alt_function_override_pkg::PAD_PULLUP_RST
		&& pad_out == port_alt_function_override_pkg::PAD_OUT_RST))
		else $error("pads not parked in reset");

endmodule : port_alt_function_override

// ### verif/pad_load_model.sv
// external load on the nine pads: outside drivers, pull-ups and floating lines
// assumes the pad controls come from the override block on clk_in
`timescale 1ns/1ps

module pad_load_model (
	input wire logic clk_in,
	input wire logic [8:0] pad_out_in,
	input wire logic [8:0] pad_oe_n_in,
	input wire logic [8:0] pad_pullup_in,
	input wire logic [8:0] ext_en_in,
	input wire logic [8:0] ext_val_in,
	output logic [8:0] pad_level_out
);
	logic [8:0] wander = 9'h0a5;

	// a floating pad changes every cycle, so a stale level never passes
	always_ff @(posedge clk_in) begin
		wander <= ~wander;
	end

	// device drive, outside drive, a clash, the pull-up, or nothing at all
	always_comb begin
		for (int i = 0; i < 9; i++) begin
			if (!pad_oe_n_in[i] && ext_en_in[i]) pad_level_out[i] = 1'bx;
			else if (!pad_oe_n_in[i]) pad_level_out[i] = pad_out_in[i];
			else if (ext_en_in[i]) pad_level_out[i] = ext_val_in[i];
			else if (pad_pullup_in[i]) pad_level_out[i] = 1'b1;
			else pad_level_out[i] = wander[i];
		end
	end
endmodule : pad_load_model

// ### verif/port_alt_function_override_tb.sv
// self-checking bench for the pad override block with a pad load model
// assumes one 20 MHz clock; all control inputs packed into one stimulus word
`timescale 1ns/1ps

module port_alt_function_override_tb;
	logic clk_in;
	logic srst_in;
	logic [79:0] v;
	logic [95:0] r;
	logic [31:0] seed_sink;
	logic [8:0] pad_in, pad_out, pad_oe_n_out, pad_pullup_out, digital_in_out, pin_change_out;
	logic serial_clk_in_out, serial_data_in_out, timer1_capture_in_out;
	int bad_count;
	int total_checks;

	port_alt_function_override dut_u (.clk_in(clk_in), .srst_in(srst_in),
		.port_a_out_in(v[7:0]), .port_a_dir_in(v[15:8]), .port_b_out0_in(v[33]),
		.port_b_dir0_in(v[34]), .pullup_disable_in(v[35]), .sleep_in(v[36]),
		.analog_input_disable_in(v[23:16]), .pin_change_src_in(v[32:24]),
		.pin_change_group0_en_in(v[37]), .pin_change_group1_en_in(v[38]),
		.serial_wire_mode_b1_in(v[39]), .serial_wire_mode_b0_in(v[40]),
		.serial_start_irq_en_in(v[41]), .serial_clk_hold_in(v[42]),
		.serial_clk_toggle_in(v[43]), .serial_data_out_in(v[44]), .serial_sda_out_in(v[45]),
		.timer1_cmp_a_en_in(v[46]), .timer1_cmp_a_out_in(v[47]), .timer1_cmp_b_en_in(v[48]),
		.timer1_cmp_b_out_in(v[49]), .timer0_cmp_b_en_in(v[50]), .timer0_cmp_b_out_in(v[51]),
		.ref_select_b1_in(v[52]), .ref_select_b0_in(v[53]), .osc_is_rc_in(v[54]),
		.pad_in(pad_in), .pad_out(pad_out), .pad_oe_n_out(pad_oe_n_out),
		.pad_pullup_out(pad_pullup_out), .digital_in_out(digital_in_out),
		.pin_change_out(pin_change_out), .serial_clk_in_out(serial_clk_in_out),
		.serial_data_in_out(serial_data_in_out), .timer1_capture_in_out(timer1_capture_in_out));

	pad_load_model load_u (.clk_in(clk_in), .pad_out_in(pad_out), .pad_oe_n_in(pad_oe_n_out),
		.pad_pullup_in(pad_pullup_out), .ext_en_in(v[63:55]), .ext_val_in(v[72:64]),
		.pad_level_out(pad_in));

	// 50 ns clock
	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end

	// expected pad controls and input enables for one stimulus word
	function automatic void model(input logic [79:0] s, output logic [8:0] oen,
		output logic [8:0] po, output logic [8:0] pu, output logic [8:0] ien);
		logic [8:0] o, d, src;
		logic ovr;
		o = {s[33], s[7:0]};
		d = {s[34], s[15:8]};
		src = s[32:24];
		oen = ~d;
		po = o;
		po[4] = o[4] ^ s[43];
		pu = ~d & o & {9{~s[35]}};
		if (s[39]) oen[4] = ~(~(s[42] | o[4]) & d[4]);
		if (s[39] & d[4]) po[4] = 1'b0;
		if (s[39] & s[40]) po[5] = s[44];
		else if (s[48]) po[5] = s[49];
		if (s[39]) oen[6] = ~((s[45] | o[6]) & d[6]);
		if ((s[39] & d[6]) | s[46]) po[6] = ~(s[39] & d[6]) & s[47];
		if (s[50]) po[7] = s[51];
		if (s[53]) begin
			oen[0] = 1'b1;
			po[0] = 1'b0;
			pu[0] = 1'b0;
		end
		if (!s[54]) begin
			oen[8] = 1'b1;
			po[8] = 1'b0;
			pu[8] = 1'b0;
		end
		for (int i = 0; i < 8; i++) begin
			ovr = (src[i] & s[37]) | (((i == 4) || (i == 6)) & s[41]);
			ien[i] = (ovr | s[16 + i]) ? ovr : ~s[36];
		end
		ien[8] = s[54] & ((src[8] & s[38]) | ~s[36]);
	endfunction : model

	// masked compare, counted
	task automatic chk(input logic [8:0] got, input logic [8:0] exp, input logic [8:0] m,
		input string what);
		total_checks++;
		if (((got ^ exp) & m) !== 9'h000) begin
			bad_count++;
			$display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : chk

	// apply one word, check drive after one edge and inputs after the synchroniser
	task automatic run_vec(input logic [79:0] s);
		logic [8:0] oen, po, pu, ien, lvl, kn, m, ei;
		@(posedge clk_in);
		v <= s;
		@(posedge clk_in);
		#1;
		model(s, oen, po, pu, ien);
		m = {4'hf, ~(s[39] & s[43]), 4'hf};
		chk(pad_oe_n_out, oen, m, "driver");
		chk(pad_pullup_out, pu, m, "pullup");
		chk(pad_out, po, ~oen & m, "value");
		repeat (4) @(posedge clk_in);
		#1;
		lvl = (~oen & po) | (oen & s[63:55] & s[72:64]) | (oen & ~s[63:55] & pu);
		kn = (~oen & ~s[63:55]) | (oen & s[63:55]) | (oen & pu);
		ei = lvl & ien;
		m = (kn | ~ien) & m;
		chk(digital_in_out, ei, m, "input");
		chk(pin_change_out, ei, m, "change");
		chk({6'h00, timer1_capture_in_out, serial_data_in_out, serial_clk_in_out},
			{6'h00, ei[7], ei[6], ei[4]}, {6'h00, m[7], m[6], m[4]}, "alt");
	endtask : run_vec

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : tally_and_finish

	// corners, random words, a reset in mid-run
	initial begin
		v = '0;
		srst_in = 1'b1;
		bad_count = 0;
		total_checks = 0;
		seed_sink = $urandom(32'h9a47_6fb3);
		repeat (2) @(posedge clk_in);
		srst_in <= 1'b0;
		run_vec(80'h0000_0040_1180_0000_2000);
		run_vec('0);
		run_vec(80'hffff_ffff_ffff_ffff_ffff);
		for (int k = 0; k < 400; k++) begin
			r = {$urandom, $urandom, $urandom};
			run_vec(r[79:0]);
		end
		@(posedge clk_in);
		srst_in <= 1'b1;
		@(posedge clk_in);
		#1;
		chk(pad_oe_n_out, port_alt_function_override_pkg::PAD_OE_N_RST, 9'h1ff, "rst");
		chk(pad_pullup_out, port_alt_function_override_pkg::PAD_PULLUP_RST, 9'h1ff, "rst");
		chk(pad_out, port_alt_function_override_pkg::PAD_OUT_RST, 9'h1ff, "rst");
		@(posedge clk_in);
		srst_in <= 1'b0;
		run_vec(80'h0000_0040_1180_0000_2000);
		tally_and_finish;
	end
endmodule : port_alt_function_override_tb
